// ### hdl/word_link_pkg.sv
package word_link_pkg;

  // ==========================================================
  // Word layout
  localparam int DATA_BITS     = 12;
  localparam int CODE_BITS     = 2;
  localparam int SLOT_BITS     = DATA_BITS + CODE_BITS;   // 14 bit shift pulses
  localparam int STROBE_SLOT   = SLOT_BITS;               // slot 14 carries the strobe
  localparam int SLOTS_PER_CYC = SLOT_BITS + 1;

  // ==========================================================
  // Control codes, written {second bit, first bit}
  localparam logic [1:0] CODE_NOP   = 2'h0;
  localparam logic [1:0] CODE_WRITE = 2'h1;   // input or memory write
  localparam logic [1:0] CODE_SHIFT = 2'h2;
  localparam logic [1:0] CODE_READ  = 2'h3;   // output or memory read

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS    = 8;
  localparam int PULSE_PERIOD_NS  = 1000;
  localparam int PULSE_DUTY_PCT   = 50;
  localparam int PULSE_PERIOD_CYC = PULSE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int PULSE_LOW_CYC    = (PULSE_PERIOD_CYC * PULSE_DUTY_PCT) / 100;

  // Peer bit counter value while not yet aligned to a strobe
  localparam logic [3:0] SLOT_UNSYNCED = 4'hF;
  localparam logic [3:0] SLOT_LAST     = 4'(SLOT_BITS - 1);
  localparam logic [3:0] SLOT_CODE_HI  = 4'h1;

  // ==========================================================
  // Page selector width and data switch ways
  localparam int PAGE_BITS = 4;
  localparam int WAYS      = 16;

  // Two-of-three vote
  function automatic logic majority3(input logic [2:0] v);
    majority3 = (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
  endfunction

endpackage

// ### hdl/word_link_if.sv
`timescale 1ns/1ps
interface word_link_if;
  logic [2:0] bit_shift_pulse_n;       // Triplicated, active low
  logic [2:0] word_boundary_strobe_n;  // Triplicated, active low
  logic       ser_to_module;           // Control code then data, LSB first
  logic       ser_to_logic;            // Return line, idles low

  modport logic_unit (
    output bit_shift_pulse_n,
    output word_boundary_strobe_n,
    output ser_to_module,
    input  ser_to_logic
  );

  modport peer (
    input  bit_shift_pulse_n,
    input  word_boundary_strobe_n,
    input  ser_to_module,
    output ser_to_logic
  );
endinterface

// ### hdl/basic_register.sv
`timescale 1ns/1ps
module basic_register #(
  parameter int WIDTH = 12
) (
  // Clock and reset
  input  wire logic             i_clk_sys,
  input  wire logic             i_reset_n,
  // Controls
  input  wire logic             i_shift,
  input  wire logic             i_load,
  input  wire logic             i_ser_in,
  input  wire logic [WIDTH-1:0] i_par_in,
  // Contents
  output logic      [WIDTH-1:0] o_q
);

  initial begin
    if (WIDTH < 2) $error("basic_register needs at least two stages");
  end

  // ==========================================================
  // Stages: load takes priority, the gating inverts each parallel input
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_stage
      logic from_left;
      if (g == WIDTH - 1) begin : g_top
        assign from_left = i_ser_in;
      end else begin : g_mid
        assign from_left = o_q[g+1];
      end
      always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
          o_q[g] <= 1'b0;
        end else if (i_load) begin
          o_q[g] <= ~i_par_in[g];        // [R14] [R15]
        end else if (i_shift) begin
          o_q[g] <= from_left;           // [R13]
        end
      end
    end
  endgenerate

endmodule

// ### hdl/peer_module_end.sv
`timescale 1ns/1ps
module peer_module_end (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset_n,
  // Link
  word_link_if.peer        link,
  // User side
  input  wire logic        i_assigned,
  input  wire logic        i_load,
  input  wire logic [11:0] i_load_value,
  output logic      [11:0] o_word_value,
  output logic      [1:0]  o_last_code,
  output logic             o_word_done
);

  // ==========================================================
  // Voted timing and trailing-edge detection
  logic       shift_v;
  logic       strobe_v;
  logic       shift_prev_reg;
  logic       strobe_prev_reg;
  logic       bit_edge;
  logic       word_edge;
  logic [3:0] slot_reg;
  logic [1:0] code_reg;
  logic       code_lo_n_reg;
  logic       active_reg;
  logic       drive_reg;
  logic       ret_reg;
  logic       step;
  logic [11:0] q;

  assign shift_v   = word_link_pkg::majority3(link.bit_shift_pulse_n);      // [R3]
  assign strobe_v  = word_link_pkg::majority3(link.word_boundary_strobe_n); // [R3]
  assign bit_edge  = shift_v & ~shift_prev_reg;     // Rising end of low pulse [R4]
  assign word_edge = strobe_v & ~strobe_prev_reg;   // [R4]

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      shift_prev_reg  <= 1'b1;
      strobe_prev_reg <= 1'b1;
    end else begin
      shift_prev_reg  <= shift_v;
      strobe_prev_reg <= strobe_v;
    end
  end

  // Slot counter; stays unsynced until the first strobe aligns it
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      slot_reg <= word_link_pkg::SLOT_UNSYNCED;
    end else if (word_edge) begin
      slot_reg <= 4'h0;
    end else if (bit_edge && slot_reg <= word_link_pkg::SLOT_LAST) begin
      slot_reg <= slot_reg + 4'h1;
    end
  end

  // ==========================================================
  // Control code capture; an unassigned module reads every code as no-op
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      code_reg      <= word_link_pkg::CODE_NOP;
      code_lo_n_reg <= 1'b1;
    end else if (bit_edge && slot_reg == 4'h0) begin
      code_reg[0]   <= link.ser_to_module & i_assigned;      // AND capture [R11] [R21] [R6]
      code_lo_n_reg <= ~(link.ser_to_module & i_assigned);   // NAND copy [R12]
    end else if (bit_edge && slot_reg == word_link_pkg::SLOT_CODE_HI) begin
      code_reg[1]   <= link.ser_to_module & i_assigned;      // [R11] [R21] [R7]
    end
  end

  // Set-reset style activity flag; set and reset fall in different slots,
  // and its own output never feeds its set or reset terms
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      active_reg <= 1'b0;
    end else if (bit_edge && slot_reg == word_link_pkg::SLOT_CODE_HI &&
                 (link.ser_to_module & i_assigned | ~code_lo_n_reg)) begin
      active_reg <= 1'b1;                                    // [R9] [R10]
    end else if (word_edge || (bit_edge && slot_reg == word_link_pkg::SLOT_LAST)) begin
      active_reg <= 1'b0;                                    // [R9]
    end
  end

  // ==========================================================
  // Data handling per code
  assign step = bit_edge && active_reg && slot_reg > word_link_pkg::SLOT_CODE_HI &&
                slot_reg <= word_link_pkg::SLOT_LAST;        // [R8]

  basic_register #(.WIDTH(12)) u_word (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .i_shift   (step),
    .i_load    (i_load & ~active_reg),
    .i_ser_in  ((code_reg == word_link_pkg::CODE_READ) ? q[0] : link.ser_to_module), // [R8]
    .i_par_in  (~i_load_value),          // Pre-inverted so the stored word is true
    .o_q       (q)
  );

  // Return line: read and shift put out the old word LSB first
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      drive_reg <= 1'b0;
      ret_reg   <= 1'b0;
    end else begin
      drive_reg <= active_reg && code_reg[1];                // [R8] [R23]
      ret_reg   <= drive_reg & q[0];                         // [R1] [R23]
    end
  end
  assign link.ser_to_logic = ret_reg;

  // User status
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_last_code <= word_link_pkg::CODE_NOP;
      o_word_done <= 1'b0;
    end else begin
      o_word_done <= word_edge;
      if (word_edge) begin
        o_last_code <= code_reg;
      end
    end
  end
  assign o_word_value = q;

endmodule

// ### hdl/logic_unit_end.sv
`timescale 1ns/1ps
// Summary of operation
// [R1]: Words move bit-serially on one line only.
// [R2]: Fourteen shift pulses, then one strobe, 1 us.
// [R3]: Timing sent triplicated, majority voted at receiver.
// [R4]: Active-low pulses; storage updates on trailing edge.
// [R5]: Timing pulses run at half duty cycle.
// [R6]: Two code bits precede twelve data bits.
// [R7]: Logic unit commands modules only through codes.
// [R8]: Codes: 00 nop, 10 shift, 11 read, 01 write.
// [R9]: Set-reset cell sets or clears; never both.
// [R10]: Set-reset outputs never feed same-clock set-reset inputs.
// [R11]: AND cell captures input AND at clock edge.
// [R12]: NAND cell stores complement of the AND.
// [R13]: Basic register shifts right when shift high.
// [R14]: Parallel load takes all twelve inputs at once.
// [R15]: Parallel load stores inverted input bits.
// [R16]: Neighbour-tied inputs turn load into shift-left.
// [R17]: Both accumulators are left/right basic registers.
// [R18]: Switch decodes four select bits into sixteen ways.
// [R19]: Separate global enables for input and output paths.
// [R20]: Sixteen gated inputs are ORed into one.
// [R21]: Module answers only its assigned logic unit.
// [R22]: Separate four-bit program and data page selectors.
// [R23]: Serial words go LSB first, codes before bit zero.
module logic_unit_end (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset_n,
  // Link
  word_link_if.logic_unit  link,
  // Next word to send
  input  wire logic [1:0]  i_next_code,
  input  wire logic [11:0] i_next_word,
  // Received word
  output logic      [11:0] o_rx_word,
  output logic             o_word_done,
  output logic             o_bit_edge,
  // Accumulators
  input  wire logic        i_acc_select,
  input  wire logic        i_acc_shift_right,
  input  wire logic        i_acc_shift_left,
  input  wire logic        i_acc_left_in,
  input  wire logic        i_acc_right_in,
  output logic      [11:0] o_acc_a,
  output logic      [11:0] o_acc_b,
  // Data switch
  input  wire logic [3:0]  i_way_select,
  input  wire logic        i_input_enable,
  input  wire logic        i_output_enable,
  input  wire logic [15:0] i_way_in,
  input  wire logic        i_switch_data,
  output logic             o_switch_combined,
  output logic      [15:0] o_way_out,
  // Page selection
  input  wire logic        i_page_write,
  input  wire logic        i_page_is_data,
  input  wire logic [3:0]  i_page_value,
  output logic      [3:0]  o_program_page_select,
  output logic      [3:0]  o_data_page_select,
  output logic             o_pages_same
);

  localparam logic [6:0] PERIOD_LAST = 7'(word_link_pkg::PULSE_PERIOD_CYC - 1);
  localparam logic [6:0] LOW_END     = 7'(word_link_pkg::PULSE_LOW_CYC);
  localparam logic [3:0] STROBE_SLOT = 4'(word_link_pkg::STROBE_SLOT);
  localparam logic [3:0] FIRST_DATA  = 4'(word_link_pkg::CODE_BITS);

  initial begin
    if (word_link_pkg::PULSE_PERIOD_CYC > 127) $error("pulse period too long for counter");
    if (word_link_pkg::PULSE_LOW_CYC < 1) $error("pulse low time below one cycle");
  end

  // ==========================================================
  // Timing generator
  logic [6:0]  cyc_reg;
  logic [3:0]  slot_reg;
  logic        pulse_low;
  logic        trail;
  logic        shift_n_reg;
  logic        strobe_n_reg;

  assign pulse_low = cyc_reg < LOW_END;                      // 50 percent low [R5]
  assign trail     = cyc_reg == LOW_END;                     // Pulse returns high here

  // Period and slot counters; fourteen bit slots then one strobe slot
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      cyc_reg  <= 7'h00;
      slot_reg <= 4'h0;
    end else if (cyc_reg == PERIOD_LAST) begin
      cyc_reg  <= 7'h00;
      slot_reg <= (slot_reg == STROBE_SLOT) ? 4'h0 : slot_reg + 4'h1;  // [R2]
    end else begin
      cyc_reg  <= cyc_reg + 7'h01;
    end
  end

  // Registered active-low pulses; held high during reset
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      shift_n_reg  <= 1'b1;
      strobe_n_reg <= 1'b1;
    end else begin
      shift_n_reg  <= ~(pulse_low && slot_reg != STROBE_SLOT);  // [R2] [R4]
      strobe_n_reg <= ~(pulse_low && slot_reg == STROBE_SLOT);  // [R2] [R4]
    end
  end

  // Three identical copies so a single broken wire is outvoted
  assign link.bit_shift_pulse_n      = {3{shift_n_reg}};        // [R3]
  assign link.word_boundary_strobe_n = {3{strobe_n_reg}};       // [R3]

  // ==========================================================
  // Serial transmit and receive
  logic [13:0] tx_reg;
  logic [11:0] rx_reg;
  logic        ser_reg;
  logic        bit_trail;
  logic        word_trail;

  // Registered pulse ends lag one cycle, so events line up with the pins
  assign bit_trail  = trail && slot_reg != STROBE_SLOT;
  assign word_trail = trail && slot_reg == STROBE_SLOT;

  // Code in the low bits leaves first, then data LSB first
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      tx_reg <= 14'h0000;
    end else if (word_trail) begin
      tx_reg <= {i_next_word, i_next_code};                  // [R6] [R7] [R23]
    end else if (bit_trail) begin
      tx_reg <= {1'b0, tx_reg[13:1]};                        // [R23]
    end
  end

  // Line changes at slot start, half a period away from the sampling edge
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      ser_reg <= 1'b0;
    end else if (cyc_reg == 7'h00) begin
      ser_reg <= (slot_reg == STROBE_SLOT) ? 1'b0 : tx_reg[0];  // [R1]
    end
  end
  assign link.ser_to_module = ser_reg;

  // Return bits sampled at each data slot's trailing edge
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      rx_reg <= 12'h000;
    end else if (bit_trail && slot_reg >= FIRST_DATA) begin
      rx_reg <= {link.ser_to_logic, rx_reg[11:1]};           // [R1] [R23]
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_rx_word   <= 12'h000;
      o_word_done <= 1'b0;
      o_bit_edge  <= 1'b0;
    end else begin
      o_word_done <= word_trail;
      o_bit_edge  <= bit_trail;
      if (word_trail) begin
        o_rx_word <= rx_reg;
      end
    end
  end

  // ==========================================================
  // Accumulators: each stage loads from its right neighbour through the
  // inverting gate, pre-inverted here so a load becomes a left shift
  logic [11:0] acc_a;
  logic [11:0] acc_b;
  logic        step_a;
  logic        step_b;

  assign step_a = bit_trail & ~i_acc_select;
  assign step_b = bit_trail & i_acc_select;

  basic_register #(.WIDTH(12)) u_acc_a (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .i_shift   (step_a & i_acc_shift_right),                 // [R16] [R17]
    .i_load    (step_a & i_acc_shift_left),                  // [R16] [R17]
    .i_ser_in  (i_acc_left_in),
    .i_par_in  (~{acc_a[10:0], i_acc_right_in}),             // [R16]
    .o_q       (acc_a)
  );

  basic_register #(.WIDTH(12)) u_acc_b (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .i_shift   (step_b & i_acc_shift_right),                 // [R16] [R17]
    .i_load    (step_b & i_acc_shift_left),                  // [R16] [R17]
    .i_ser_in  (i_acc_left_in),
    .i_par_in  (~{acc_b[10:0], i_acc_right_in}),             // [R16]
    .o_q       (acc_b)
  );

  assign o_acc_a = acc_a;
  assign o_acc_b = acc_b;

  // ==========================================================
  // Sixteen-way data switch
  logic [15:0] way_hit;
  logic [15:0] in_gated;

  genvar w;
  generate
    for (w = 0; w < word_link_pkg::WAYS; w++) begin : g_way
      assign way_hit[w]  = i_way_select == 4'(w);                          // [R18]
      assign in_gated[w] = way_hit[w] & i_input_enable & i_way_in[w];      // [R19]
      always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
          o_way_out[w] <= 1'b0;
        end else begin
          o_way_out[w] <= way_hit[w] & i_output_enable & i_switch_data;    // [R19]
        end
      end
    end
  endgenerate

  // Gated inputs share one OR so only one pin leaves the switch
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_switch_combined <= 1'b0;
    end else begin
      o_switch_combined <= |in_gated;                        // [R20]
    end
  end

  // ==========================================================
  // Program and data page selectors
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_program_page_select <= 4'h0;
      o_data_page_select    <= 4'h0;
    end else if (i_page_write) begin
      if (i_page_is_data) begin
        o_data_page_select <= i_page_value;                  // [R22]
      end else begin
        o_program_page_select <= i_page_value;               // [R22]
      end
    end
  end

  // Same-page flag lags the selectors by one cycle
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_pages_same <= 1'b1;
    end else begin
      o_pages_same <= o_program_page_select == o_data_page_select;  // [R22]
    end
  end

endmodule

// ### verif/word_link_sva.sv
`timescale 1ns/1ps
module word_link_sva (
  // Clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_reset_n,
  // Link
  input  wire logic [2:0] bit_shift_pulse_n,
  input  wire logic [2:0] word_boundary_strobe_n,
  input  wire logic       ser_to_module,
  input  wire logic       ser_to_logic
);
  // ==========================================================
  // Helper counters
  logic [6:0] low_cnt_reg;
  logic [6:0] per_cnt_reg;
  logic [3:0] pls_cnt_reg;
  logic       low_prev_reg;
  logic       seen_reg;
  logic       fall_now;

  // Copy 0 of either timing signal going low starts a new slot
  assign fall_now = (~bit_shift_pulse_n[0] | ~word_boundary_strobe_n[0]) & ~low_prev_reg;

  // Pulse width, slot length and pulses since the last strobe
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      low_cnt_reg  <= 7'h00;
      per_cnt_reg  <= 7'h00;
      pls_cnt_reg  <= 4'h0;
      low_prev_reg <= 1'b0;
      seen_reg     <= 1'b0;
    end else begin
      low_cnt_reg  <= bit_shift_pulse_n[0] ? 7'h00 : low_cnt_reg + 7'h01;
      per_cnt_reg  <= fall_now ? 7'h00 : per_cnt_reg + 7'h01;
      low_prev_reg <= ~bit_shift_pulse_n[0] | ~word_boundary_strobe_n[0];
      seen_reg     <= seen_reg | fall_now;
      if (fall_now && !word_boundary_strobe_n[0]) begin
        pls_cnt_reg <= 4'h0;
      end else if (fall_now) begin
        pls_cnt_reg <= pls_cnt_reg + 4'h1;
      end
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_reset_n);

  chk_copies_agree: assert property (
    bit_shift_pulse_n == {3{bit_shift_pulse_n[0]}} &&
    word_boundary_strobe_n == {3{word_boundary_strobe_n[0]}})
    else $error("timing copies differ");
  chk_reset_idle: assert property (
    disable iff (1'b0) !i_reset_n |=> (&bit_shift_pulse_n && &word_boundary_strobe_n))
    else $error("timing pins active in reset");
  chk_never_both: assert property (
    !(!bit_shift_pulse_n[0] && !word_boundary_strobe_n[0]))
    else $error("shift and strobe low together");
  chk_half_duty: assert property (
    $rose(bit_shift_pulse_n[0]) |-> low_cnt_reg == 7'(word_link_pkg::PULSE_LOW_CYC))
    else $error("pulse low time wrong");
  chk_slot_period: assert property (
    fall_now && seen_reg |-> per_cnt_reg == 7'(word_link_pkg::PULSE_PERIOD_CYC - 1))
    else $error("slot period wrong");
  chk_fourteen_pulses: assert property (
    fall_now && !word_boundary_strobe_n[0] |-> pls_cnt_reg == 4'hE)
    else $error("strobe not after fourteen pulses");
  chk_pulse_bound: assert property (
    fall_now && !bit_shift_pulse_n[0] |-> pls_cnt_reg < 4'hE)
    else $error("too many shift pulses");
  chk_line_steady: assert property (
    !bit_shift_pulse_n[0] && !$fell(bit_shift_pulse_n[0]) |-> $stable(ser_to_module))
    else $error("serial line moved inside pulse");
  chk_return_idle: assert property (
    !word_boundary_strobe_n[0] |-> !ser_to_logic)
    else $error("return line busy in strobe slot");

  // Main scenarios reached
  cover property (fall_now && !word_boundary_strobe_n[0]);
  cover property ($rose(ser_to_logic));
  cover property ($rose(ser_to_module));
endmodule

// ### verif/serial_word_module_datapath_bench.sv
`timescale 1ns/1ps
module serial_word_module_datapath_bench;
  localparam int CYC = word_link_pkg::SLOTS_PER_CYC * word_link_pkg::PULSE_PERIOD_CYC;
  // ==========================================================
  // Stimulus and observed signals
  logic        i_clk_sys = 1'b0;
  logic        i_reset_n = 1'b0;
  logic [1:0]  nx_code   = 2'h0;
  logic [11:0] nx_word   = 12'h000;
  logic        asg = 1'b1, pld = 1'b0, a_sel = 1'b0, a_sr = 1'b0, a_sl = 1'b0;
  logic        a_li = 1'b0, a_ri = 1'b0, w_ie = 1'b0, w_oe = 1'b0, w_d = 1'b0;
  logic        pg_wr = 1'b0, pg_d = 1'b0;
  logic [3:0]  w_sel = 4'h0, pg_v = 4'h0, pp, dp;
  logic [15:0] w_in = 16'h0000, way_out;
  logic [11:0] pval = 12'h000, rx, acc_a, acc_b, pw;
  logic [1:0]  pc;
  logic        lu_done, bit_edge, sw_c, same, pdone;
  logic [13:0] cap   = 14'h0000;
  logic        pls_q = 1'b1;
  int          n_mismatch = 0;
  int          n_compared = 0;

  always #4 i_clk_sys = ~i_clk_sys;

  word_link_if lnk ();
  logic_unit_end u_logic_unit_end (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .link(lnk),
    .i_next_code(nx_code), .i_next_word(nx_word), .o_rx_word(rx), .o_word_done(lu_done),
    .o_bit_edge(bit_edge), .i_acc_select(a_sel), .i_acc_shift_right(a_sr),
    .i_acc_shift_left(a_sl), .i_acc_left_in(a_li), .i_acc_right_in(a_ri), .o_acc_a(acc_a),
    .o_acc_b(acc_b), .i_way_select(w_sel), .i_input_enable(w_ie), .i_output_enable(w_oe),
    .i_way_in(w_in), .i_switch_data(w_d), .o_switch_combined(sw_c), .o_way_out(way_out),
    .i_page_write(pg_wr), .i_page_is_data(pg_d), .i_page_value(pg_v),
    .o_program_page_select(pp), .o_data_page_select(dp), .o_pages_same(same));
  peer_module_end u_peer_module_end (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .link(lnk),
    .i_assigned(asg), .i_load(pld), .i_load_value(pval), .o_word_value(pw),
    .o_last_code(pc), .o_word_done(pdone));
  word_link_sva u_word_link_sva (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
    .bit_shift_pulse_n(lnk.bit_shift_pulse_n), .ser_to_module(lnk.ser_to_module),
    .word_boundary_strobe_n(lnk.word_boundary_strobe_n), .ser_to_logic(lnk.ser_to_logic));

  // Rebuild the sent word from the wire, first bit ends lowest
  always @(posedge i_clk_sys) begin
    pls_q <= lnk.bit_shift_pulse_n[0];
    if (lnk.bit_shift_pulse_n[0] && !pls_q) begin
      cap <= {lnk.ser_to_module, cap[13:1]};
    end
  end

  // ==========================================================
  // Tasks
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Bounded wait: 0 word end, 1 bit edge, 2 peer word end
  task automatic wait_on(input int k, output int n);
    logic s;
    n = 0;
    do begin
      @(posedge i_clk_sys);
      #1;
      n++;
      s = (k == 0) ? lu_done : (k == 1) ? bit_edge : pdone;
    end while (s !== 1'b1 && n < 4000);
    if (n >= 4000) begin
      n_mismatch++;
      $display("MISMATCH wait %0d expected event seen none", k);
      end_sim();
    end
  endtask

  // Code is taken at the next word end, so it is dropped to nop right after
  task automatic xfer(input logic [1:0] c, input logic [11:0] w, erx, ev);
    int n;
    @(posedge i_clk_sys);
    nx_code <= c;
    nx_word <= w;
    wait_on(0, n);
    @(posedge i_clk_sys);
    nx_code <= word_link_pkg::CODE_NOP;
    nx_word <= 12'h000;
    wait_on(0, n);
    cmp("period", 16'(CYC - 1), 16'(n));
    cmp("wire_word", {2'h0, w, c}, {2'h0, cap});
    cmp("rx_word", {4'h0, erx}, {4'h0, rx});
    wait_on(2, n);
    cmp("peer_value", {4'h0, ev}, {4'h0, pw});
    cmp("peer_code", {14'h0, asg ? c : 2'h0}, {14'h0, pc});
  endtask

  // One accumulator step at the second bit slot of a word
  task automatic acc(input logic s, r, l, li, ri);
    int n;
    wait_on(0, n);
    wait_on(1, n);
    @(posedge i_clk_sys);
    a_sel <= s;
    a_sr  <= r;
    a_sl  <= l;
    a_li  <= li;
    a_ri  <= ri;
    wait_on(1, n);
    @(posedge i_clk_sys);
    a_sr <= 1'b0;
    a_sl <= 1'b0;
    #1;
  endtask

  task automatic sw(input logic [3:0] s, input logic [15:0] wi, input logic ie, oe, d, ec,
                    input logic [15:0] eo);
    @(posedge i_clk_sys);
    w_sel <= s;
    w_in  <= wi;
    w_ie  <= ie;
    w_oe  <= oe;
    w_d   <= d;
    @(posedge i_clk_sys);
    #1;
    cmp("combined", {15'h0, ec}, {15'h0, sw_c});
    cmp("way_out", eo, way_out);
  endtask

  // ==========================================================
  // Main sequence
  logic [1:0]  tc [5] = '{2'h3, 2'h1, 2'h2, 2'h0, 2'h1};
  logic [11:0] tw [5] = '{12'h000, 12'h3C7, 12'h1E1, 12'hFFF, 12'h555};
  logic [11:0] tr [5] = '{12'hA5C, 12'h000, 12'h3C7, 12'h000, 12'h000};
  logic [11:0] tv [5] = '{12'hA5C, 12'h3C7, 12'h1E1, 12'h1E1, 12'h1E1};
  initial begin
    repeat (2) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    pld       <= 1'b1;
    pval      <= 12'hA5C;
    @(posedge i_clk_sys);
    pld   <= 1'b0;
    #1;
    cmp("pages_same", 16'h0001, {15'h0, same});
    cmp("reg_load", 16'h0A5C, {4'h0, pw});
    @(posedge i_clk_sys);
    #1;
    cmp("acc_idle", 16'h0000, {4'h0, acc_a});
    cmp("peer_load", 16'h0A5C, {4'h0, pw});
    $display("test basic register done");
    for (int i = 0; i < 16; i++) begin
      sw(4'(i), 16'h0001 << i, 1'b1, 1'b1, 1'b1, 1'b1, 16'h0001 << i);
      sw(4'(i), ~(16'h0001 << i), 1'b1, 1'b0, 1'b1, 1'b0, 16'h0000);
    end
    sw(4'h3, 16'hFFFF, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0000);
    $display("test data switch done");
    @(posedge i_clk_sys);
    pg_wr <= 1'b1;
    pg_v  <= 4'h5;
    @(posedge i_clk_sys);
    pg_d <= 1'b1;
    pg_v <= 4'h9;
    @(posedge i_clk_sys);
    pg_wr <= 1'b0;
    #1;
    cmp("data_page", 16'h0009, {12'h0, dp});
    cmp("pages_same", 16'h0000, {15'h0, same});
    @(posedge i_clk_sys);
    pg_wr <= 1'b1;
    pg_v  <= 4'h5;
    @(posedge i_clk_sys);
    pg_wr <= 1'b0;
    @(posedge i_clk_sys);
    #1;
    cmp("prog_page", 16'h0005, {12'h0, pp});
    cmp("pages_same", 16'h0001, {15'h0, same});
    $display("test page select done");
    acc(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    cmp("acc_a", 16'h0800, {4'h0, acc_a});
    acc(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    cmp("acc_a", 16'h0400, {4'h0, acc_a});
    acc(1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    cmp("acc_a", 16'h0801, {4'h0, acc_a});
    cmp("acc_b", 16'h0000, {4'h0, acc_b});
    acc(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
    cmp("acc_b", 16'h0001, {4'h0, acc_b});
    acc(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
    cmp("acc_b", 16'h0002, {4'h0, acc_b});
    $display("test accumulators done");
    for (int i = 0; i < 5; i++) begin
      if (i == 4) begin
        @(posedge i_clk_sys);
        asg <= 1'b0;
      end
      xfer(tc[i], tw[i], tr[i], tv[i]);
    end
    $display("test serial link done");
    end_sim();
  end
endmodule
